/* File: src/adc_readout_pkg.sv */
// Constants shared by the serial readout logic of the converter model.
// Assumes a 250 MHz system clock and a host-driven shift clock.
package adc_readout_pkg;
   localparam int RESULT_WIDTH = 18;
   localparam int CLK_PERIOD_PS = 4000;
   // Conversion time, longest figure, in ns
   localparam int CONV_TIME_NS = 930;
   localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int BIT_COUNT_W = 5;
   localparam logic [BIT_COUNT_W-1:0] LAST_BIT = 5'h11;
   localparam logic [BIT_COUNT_W-1:0] BIT_ZERO = 5'h00;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01,
      ST_ACQ = 2'b10
   } conv_state_t;
   typedef enum logic [1:0] {
      MODE_CS3 = 2'b00,
      MODE_CS4 = 2'b01,
      MODE_CHAIN = 2'b10
   } link_mode_t;
endpackage

/* File: src/sync2.sv */
// Two-flop synchroniser for single-bit levels.
// Assumes the input is a level from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module sync2 (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic meta;
   logic next_meta;
   logic next_dout;
   always_comb begin
      next_meta = din;
      next_dout = meta;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end
endmodule
`default_nettype wire

/* File: src/sar_adc_serial_readout.sv */
// Conversion control and serial readout of an 18-bit converter model.
// Assumes the host drives conversion_start_line, din and sclk; sclk gives falls between frames to load the result.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout
   import adc_readout_pkg::*;
#(
   parameter int WIDTH = adc_readout_pkg::RESULT_WIDTH,
   parameter int CONV_COUNT = adc_readout_pkg::CONV_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] sample_value,
   input wire logic busy_indicator_en,
   input wire logic sclk,
   input wire logic conversion_start_line,
   input wire logic din,
   output logic dout_o,
   output logic dout_oe_n,
   output logic converting,
   output logic [1:0] active_mode
);
   import adc_readout_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // System domain: conversion timing
   logic start_s;
   logic din_s;
   logic start_d;
   logic next_start_d;
   conv_state_t state;
   conv_state_t next_state;
   logic [15:0] conv_cnt;
   logic [15:0] next_conv_cnt;
   logic [WIDTH-1:0] result;
   logic [WIDTH-1:0] next_result;
   logic result_tgl;
   logic next_result_tgl;
   link_mode_t mode;
   link_mode_t next_mode;

   sync2 u_sync_start (
      .clk(clk),
      .rst(sys_rst),
      .din(conversion_start_line),
      .dout(start_s)
   );
   sync2 u_sync_din (
      .clk(clk),
      .rst(sys_rst),
      .din(din),
      .dout(din_s)
   );

   always_comb begin
      next_start_d = start_s;
      next_state = state;
      next_conv_cnt = conv_cnt;
      next_result = result;
      next_result_tgl = result_tgl;
      next_mode = mode;
      case (state)
         ST_IDLE, ST_ACQ: begin
            if (start_s && !start_d) begin
               // Mode caught at the start edge
               if (din_s) begin
                  next_mode = MODE_CS4;
               end else begin
                  next_mode = busy_indicator_en ? MODE_CS3 : MODE_CHAIN;
               end
               next_state = ST_BUSY;
               next_conv_cnt = 16'h0000;
            end
         end
         ST_BUSY: begin
            if (conv_cnt == 16'(CONV_COUNT - 1)) begin
               // Result published only once the busy span ends
               next_state = ST_ACQ;
               next_result = sample_value;
               next_result_tgl = ~result_tgl;
            end else begin
               next_state = ST_BUSY;
               next_conv_cnt = conv_cnt + 16'h0001;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         start_d <= 1'b0;
         state <= ST_IDLE;
         conv_cnt <= 16'h0000;
         result <= '0;
         result_tgl <= 1'b0;
         mode <= MODE_CS3;
      end else begin
         start_d <= next_start_d;
         state <= next_state;
         conv_cnt <= next_conv_cnt;
         result <= next_result;
         result_tgl <= next_result_tgl;
         mode <= next_mode;
      end
   end

   assign converting = (state == ST_BUSY);
   assign active_mode = mode;

   ////////////////////////////////////////////////////////////////////////
   // Link domain: shift register on the host's clock
   // The result word is stable for many sclk edges after its toggle, so
   // the toggle is synchronised and the word sampled once it lands.
   logic tgl_meta;
   logic tgl_sync;
   logic tgl_seen;
   logic chain_l;
   logic [WIDTH-1:0] shreg;
   logic [WIDTH-1:0] held;
   logic [WIDTH-1:0] next_held;
   logic [BIT_COUNT_W-1:0] bit_idx;
   logic done;
   logic next_tgl_meta;
   logic next_tgl_sync;
   logic next_tgl_seen;
   logic [WIDTH-1:0] next_shreg;
   logic [BIT_COUNT_W-1:0] next_bit_idx;
   logic next_done;
   logic sel_n;
   logic sel_r;
   logic next_sel_r;

   // Select line depends on mode: start line in 3-wire, din in 4-wire
   assign sel_n = (mode == MODE_CS4) ? din : conversion_start_line;

   always_comb begin
      next_tgl_meta = result_tgl;
      next_tgl_sync = tgl_meta;
      next_tgl_seen = tgl_sync;
      next_shreg = shreg;
      next_held = held;
      next_bit_idx = bit_idx;
      next_done = done;
      next_sel_r = sel_n;
      chain_l = (mode == MODE_CHAIN);
      if (tgl_sync != tgl_seen) begin
         // New word loaded, top bit first
         next_shreg = result;
         next_held = result;
         next_bit_idx = BIT_ZERO;
         next_done = 1'b0;
      end else if (sel_r && !sel_n) begin
         // First fall of a fresh frame already moves past the top bit
         // Word kept aside so a cut frame can be read again in full
         next_shreg = {held[WIDTH-2:0], 1'b0};
         next_bit_idx = 5'h01;
         next_done = 1'b0;
      end else if (!sel_n || chain_l) begin
         // Advance one bit per shift fall; chain fills from din
         next_shreg = {shreg[WIDTH-2:0], chain_l ? din : 1'b0};
         if (bit_idx == LAST_BIT) begin
            next_done = 1'b1;
         end else begin
            next_bit_idx = bit_idx + 5'h01;
         end
      end
   end

   always_ff @(negedge sclk) begin
      if (sys_rst) begin
         tgl_meta <= 1'b0;
         tgl_sync <= 1'b0;
         tgl_seen <= 1'b0;
         shreg <= '0;
         held <= '0;
         bit_idx <= BIT_ZERO;
         done <= 1'b1;
         sel_r <= 1'b1;
      end else begin
         tgl_meta <= next_tgl_meta;
         tgl_sync <= next_tgl_sync;
         tgl_seen <= next_tgl_seen;
         shreg <= next_shreg;
         held <= next_held;
         bit_idx <= next_bit_idx;
         done <= next_done;
         sel_r <= next_sel_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pin: enable low while driving
   // Select modes float once deselected or after the last bit; chain always drives
   always_comb begin
      // Top bit from the held word until the frame's first fall
      dout_o = (sel_r && !chain_l) ? held[WIDTH-1] : shreg[WIDTH-1];
      if (mode == MODE_CHAIN) begin
         dout_oe_n = 1'b0;
      end else begin
         dout_oe_n = sel_n | done | converting;
      end
   end
endmodule
`default_nettype wire

/* File: tb/sar_adc_readout_monitor.sv */
// Port checker for the readout block.
// Bound from the bench top; sees ports only.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_readout_monitor
   import adc_readout_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic conversion_start_line,
   input wire logic din,
   input wire logic dout_oe_n,
   input wire logic converting,
   input wire logic [1:0] active_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence idle_rise;
      $rose(conversion_start_line) && !converting;
   endsequence
   start_busy_a: assert property (idle_rise |-> ##[2:5] converting) else $error("start lost");
   busy_len_a: assert property ($rose(converting) |-> converting [*8]) else $error("busy short");
   mode_hold_a: assert property (converting && $past(converting) |-> $stable(active_mode))
      else $error("mode moved");
   cs3_off_a: assert property ($rose(conversion_start_line) && active_mode == MODE_CS3 |-> ##[0:3] dout_oe_n)
      else $error("no float");
   cs4_off_a: assert property ($rose(din) && active_mode == MODE_CS4 |-> ##[0:3] dout_oe_n)
      else $error("no float");
   cs3_on_a: assert property (
      $fell(conversion_start_line) && active_mode == MODE_CS3 && !converting |-> ##[0:3] !dout_oe_n)
      else $error("no drive");
   cs4_on_a: assert property ($fell(din) && active_mode == MODE_CS4 && !converting |-> ##[0:3] !dout_oe_n)
      else $error("no drive");
   chain_on_a: assert property (active_mode == MODE_CHAIN && !converting |-> !dout_oe_n)
      else $error("chain idle");
endmodule
`default_nettype wire

/* File: tb/adc_host_model.sv */
// Host model: start line, select and shift clock.
// Assumes the bench calls its tasks; sclk idles high.
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
   input wire logic clk,
   input wire logic dout_o,
   output logic sclk,
   output logic conversion_start_line,
   output logic din
);
   initial begin
      sclk = 1'b1;
      conversion_start_line = 1'b0;
      din = 1'b0;
   end
   task automatic pins(input logic cs, input logic d);
      @(negedge clk);
      conversion_start_line = cs;
      din = d;
   endtask
   // Offset keeps sclk edges off clk edges
   task automatic falls(input int n, input logic [35:0] up, output logic [35:0] got);
      got = '0;
      #0.5;
      for (int i = n - 1; i >= 0; i--) begin
         din = up[i];
         #3 got[i] = dout_o;
         sclk = 1'b0;
         #3 sclk = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_sar_adc_serial_readout.sv */
// Bench top: scenarios, host model and checker bind.
// Assumes package, design, host and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_serial_readout;
   import adc_readout_pkg::*;
   logic clk, sys_rst, busy_indicator_en, sclk, conversion_start_line, din, dout_o, dout_oe_n, converting;
   logic [1:0] active_mode;
   logic [17:0] sample_value;
   logic [35:0] got;
   int n, n_mismatch, total_checks;
   // Short busy span keeps the run brief
   sar_adc_serial_readout #(.CONV_COUNT(10)) dut_u (.clk, .sys_rst, .sample_value, .busy_indicator_en, .sclk,
      .conversion_start_line, .din, .dout_o, .dout_oe_n, .converting, .active_mode);
   adc_host_model host_u (.clk, .dout_o, .sclk, .conversion_start_line, .din);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic busy_wait;
      for (n = 0; n < 20 && converting !== 1'b1; n++) @(negedge clk);
      for (n = 0; n < 99 && converting === 1'b1; n++) @(negedge clk);
      check(36'(n), 36'hA);
   endtask
   // Three falls while deselected load the result
   task automatic convert(input logic [1:0] m, input logic d, input logic [17:0] v);
      @(negedge clk);
      sample_value = v;
      busy_indicator_en = (m == MODE_CS3);
      host_u.pins(1'b0, d);
      repeat (5) @(negedge clk);
      host_u.pins(1'b1, d);
      busy_wait;
      check(36'(active_mode), 36'(m));
      host_u.falls(3, {36{m == MODE_CS4}}, got);
   endtask
   task automatic read_frame(input logic [1:0] m, input logic [17:0] v, input logic [17:0] up);
      host_u.pins(m != MODE_CS3, 1'b0);
      #13 check(36'(dout_oe_n), 36'h0);
      host_u.falls(m == MODE_CHAIN ? 36 : 18, {up, 18'h0}, got);
      check(got, m == MODE_CHAIN ? {v, up} : 36'(v));
      #14 check(36'(dout_oe_n), 36'(m != MODE_CHAIN));
      host_u.pins(m != MODE_CS3, 1'b1);
   endtask
   task automatic t_cs3;
      convert(MODE_CS3, 1'b0, 18'h2A5C3);
      read_frame(MODE_CS3, 18'h2A5C3, 18'h0);
      $display("three wire done");
   endtask
   // Start line rise mid-frame must float the output
   task automatic t_abort;
      convert(MODE_CS3, 1'b0, 18'h00001);
      host_u.pins(1'b0, 1'b0);
      host_u.falls(4, 36'h0, got);
      host_u.pins(1'b1, 1'b0);
      #14 check(36'(dout_oe_n), 36'h1);
      busy_wait;
      host_u.falls(3, 36'h0, got);
      $display("abort done");
   endtask
   task automatic t_cs4;
      convert(MODE_CS4, 1'b1, 18'h3FFFF);
      read_frame(MODE_CS4, 18'h3FFFF, 18'h0);
      $display("four wire done");
   endtask
   task automatic t_chain;
      convert(MODE_CHAIN, 1'b0, 18'h20001);
      read_frame(MODE_CHAIN, 18'h20001, 18'h15A3C);
      $display("chain done");
   endtask
   initial begin
      sys_rst = 1'b1;
      sample_value = '0;
      busy_indicator_en = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      fork
         host_u.falls(2, 36'h0, got);
         repeat (5) @(negedge clk);
      join
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      t_cs3;
      t_abort;
      t_chain;
      t_cs4;
      tally_and_finish;
   end
   initial begin
      #20000;
      n_mismatch++;
      tally_and_finish;
   end
endmodule
bind sar_adc_serial_readout sar_adc_readout_monitor mon_u (.clk, .sys_rst, .conversion_start_line, .din,
   .dout_oe_n, .converting, .active_mode);
`default_nettype wire
